// File: core/irx_pkg.sv
/*
 * Shared constants and carrier types for the indexed register access block.
 * Assumes a single clock domain shared with the host I/O cycle decoder.
 */
package irx_pkg;

  // ************************************************************
  // Host I/O window layout
  // ************************************************************
  localparam logic [31:0] IRX_SEL_OFF = 32'h0000_0000;
  localparam logic [31:0] IRX_DATA_OFF = 32'h0000_0001;
  localparam logic [31:0] IRX_BAR_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] IRX_BAR_RST = 32'h0000_0000;
  localparam logic [1:0] IRX_BAR_LOW_BITS = 2'h1;

  // ************************************************************
  // Selector byte fields
  // ************************************************************
  localparam int IRX_REG_W = 6;
  localparam int IRX_SLOT_BIT = 6;
  localparam int IRX_IDX_W = 7;
  localparam int IRX_NUM_SLOT = 2;
  localparam int IRX_SPACE = 256;
  localparam int IRX_PER_SLOT = 64;
  localparam logic [7:0] IRX_SEL_RST = 8'h00;

  // ************************************************************
  // Register map landmarks within one slot
  // ************************************************************
  localparam logic [5:0] IRX_SH_REV = 6'h00;
  localparam logic [5:0] IRX_SH_MISC2 = 6'h1E;
  localparam logic [5:0] IRX_SH_INFO = 6'h1F;
  localparam logic [5:0] IRX_DEVCTL_LO = 6'h01;
  localparam logic [5:0] IRX_DEVCTL_HI = 6'h07;
  localparam logic [5:0] IRX_IOWIN_LO = 6'h08;
  localparam logic [5:0] IRX_IOWIN_HI = 6'h0F;
  localparam logic [5:0] IRX_MEMWIN0 = 6'h10;
  localparam logic [5:0] IRX_MEMWIN1 = 6'h18;
  localparam logic [5:0] IRX_MEMWIN2 = 6'h20;
  localparam logic [5:0] IRX_MEMWIN3 = 6'h28;
  localparam logic [5:0] IRX_MEMWIN_BYTES = 6'h06;
  localparam logic [5:0] IRX_IOWIN_BYTES = 6'h04;

  typedef enum logic [2:0] {
    IRX_RGN_SHARED,
    IRX_RGN_DEVCTL,
    IRX_RGN_IOWIN,
    IRX_RGN_MEMWIN,
    IRX_RGN_OTHER
  } irx_region_t;

  typedef struct packed {
    logic [31:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } irx_io_req_t;

  typedef struct packed {
    logic wr;
    logic [6:0] idx;
    logic [7:0] data;
    irx_region_t region;
    logic [1:0] win;
    logic [2:0] byte_sel;
  } irx_wr_evt_t;

endpackage

// File: core/irx_regfile.sv
/*
 * Byte-wide register storage behind the selector, two slots of 64 bytes.
 * Assumes writes arrive as single-cycle strobes from the access front end.
 */
`timescale 1ns/1ns
`default_nettype none

module irx_regfile #(
  parameter logic [7:0] CHIP_REV = 8'h00 // Arbitrary default value.
) (
  input wire logic clk_sys_i, // System clock.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic wr_i, // Write strobe.
  input wire logic [6:0] wr_idx_i, // Write index.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic [6:0] rd_idx_i, // Host read index.
  output logic [7:0] rdata_o, // Host read data.
  input wire logic [6:0] peek_idx_i, // Side read index.
  output logic [7:0] peek_o // Side read data.
);
  import irx_pkg::*;

  localparam int DEPTH = IRX_NUM_SLOT * IRX_PER_SLOT;

  logic [7:0] mem [DEPTH];
  logic [6:0] wr_phys;

  // Shared registers fold slot B onto the slot A copy.
  function automatic logic [6:0] phys(input logic [6:0] idx);
    logic [5:0] r;
    r = idx[5:0];
    if (r == IRX_SH_REV || r == IRX_SH_MISC2 || r == IRX_SH_INFO) begin
      phys = {1'b0, r};
    end else begin
      phys = idx;
    end
  endfunction

  function automatic logic [7:0] look(input logic [6:0] idx);
    logic [6:0] p;
    p = phys(idx);
    if (p == {1'b0, IRX_SH_REV}) begin
      look = CHIP_REV;
    end else begin
      look = mem[p];
    end
  endfunction

  always_comb begin
    wr_phys = phys(wr_idx_i);
  end

  // ************************************************************
  // Storage, one flip-flop byte per location
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_loc
      logic [7:0] next_byte;
      always_comb begin
        next_byte = mem[g];
        if (wr_i && wr_phys == 7'(g) && wr_phys != {1'b0, IRX_SH_REV}) begin
          next_byte = wdata_i;
        end
      end
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mem[g] <= 8'h00;
        end else begin
          mem[g] <= next_byte;
        end
      end
    end
  endgenerate

  always_comb begin
    rdata_o = look(rd_idx_i);
    peek_o = look(peek_idx_i);
  end

endmodule

`default_nettype wire

// File: core/irx_top.sv
/*
 * Indexed register access front end: selector and data bytes in host I/O
 * space, base address register, and per-slot register map decode.
 * Assumes host I/O strobes are single-cycle and synchronous to clk_sys_i.
 */
`timescale 1ns/1ns
`default_nettype none

module irx_top #(
  parameter logic [7:0] CHIP_REV = 8'h00 // Arbitrary default value.
) (
  input wire logic clk_sys_i, // System clock, 25 MHz.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic cfg_bar_wr_i, // Base address register write strobe.
  input wire logic [31:0] cfg_bar_wdata_i, // Base address write data.
  output logic [31:0] cfg_bar_rdata_o, // Base address readback.
  input wire irx_pkg::irx_io_req_t io_req_i, // Host I/O cycle.
  output logic io_ack_o, // Access hit, pulse.
  output logic [7:0] io_rdata_o, // Host read data.
  output logic [7:0] sel_o, // Selector byte contents.
  output irx_pkg::irx_wr_evt_t wr_evt_o, // Decoded register write.
  input wire logic [6:0] peek_idx_i, // Side read index.
  output logic [7:0] peek_data_o // Side read data.
);
  import irx_pkg::*;

  // ************************************************************
  // Address decode
  // ************************************************************
  logic [31:0] bar;
  logic [31:0] next_bar;
  logic [31:0] base;
  logic hit_sel;
  logic hit_data;

  // Only the two low bytes of the aligned double word decode; the other two
  // are left unclaimed so that another agent on the bus may own them.
  always_comb begin
    base = bar & IRX_BAR_MASK;
    hit_sel = io_req_i.addr == base + IRX_SEL_OFF;
    hit_data = io_req_i.addr == base + IRX_DATA_OFF;
    next_bar = bar;
    if (cfg_bar_wr_i) begin
      next_bar = cfg_bar_wdata_i & IRX_BAR_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bar <= IRX_BAR_RST;
    end else begin
      bar <= next_bar;
    end
  end

  // Low bits are constants so software sees an I/O-space window.
  always_comb begin
    cfg_bar_rdata_o = {bar[31:2], IRX_BAR_LOW_BITS};
  end

  // ************************************************************
  // Selector byte
  // ************************************************************
  logic [6:0] sel;
  logic [6:0] next_sel;

  // Only a selector write changes it; data accesses leave it alone, so
  // software must rewrite it before touching a different register.
  always_comb begin
    next_sel = sel;
    if (io_req_i.wr && hit_sel) begin
      next_sel = io_req_i.wdata[IRX_IDX_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel <= IRX_SEL_RST[IRX_IDX_W-1:0];
    end else begin
      sel <= next_sel;
    end
  end

  // The top selector bit is reserved; it is not stored and reads zero, so
  // the upper half of the 256-entry space is never reached.
  always_comb begin
    sel_o = {1'b0, sel};
  end

  // ************************************************************
  // Region classification of the selected register
  // ************************************************************
  function automatic logic in_win(input logic [5:0] r, input logic [5:0] b,
                                  input logic [5:0] n);
    in_win = (r >= b) && (r < b + n);
  endfunction

  irx_region_t region;
  logic [1:0] win;
  logic [2:0] byte_sel;
  logic [5:0] reg_no;

  // Only the low six bits are classified, so both slots share one map and
  // the slot bit travels separately in the write event.
  always_comb begin
    reg_no = sel[IRX_REG_W-1:0];
    region = IRX_RGN_OTHER;
    win = 2'd0;
    byte_sel = 3'd0;
    if (reg_no == IRX_SH_REV || reg_no == IRX_SH_MISC2 ||
        reg_no == IRX_SH_INFO) begin
      region = IRX_RGN_SHARED;
    end else if (reg_no >= IRX_DEVCTL_LO && reg_no <= IRX_DEVCTL_HI) begin
      region = IRX_RGN_DEVCTL;
      byte_sel = 3'(reg_no - IRX_DEVCTL_LO);
    end else if (reg_no >= IRX_IOWIN_LO && reg_no <= IRX_IOWIN_HI) begin
      region = IRX_RGN_IOWIN;
      win = 2'((reg_no - IRX_IOWIN_LO) / IRX_IOWIN_BYTES);
      byte_sel = 3'((reg_no - IRX_IOWIN_LO) % IRX_IOWIN_BYTES);
    end else if (in_win(reg_no, IRX_MEMWIN0, IRX_MEMWIN_BYTES)) begin
      region = IRX_RGN_MEMWIN;
      win = 2'd0;
      byte_sel = 3'(reg_no - IRX_MEMWIN0);
    end else if (in_win(reg_no, IRX_MEMWIN1, IRX_MEMWIN_BYTES)) begin
      region = IRX_RGN_MEMWIN;
      win = 2'd1;
      byte_sel = 3'(reg_no - IRX_MEMWIN1);
    end else if (in_win(reg_no, IRX_MEMWIN2, IRX_MEMWIN_BYTES)) begin
      region = IRX_RGN_MEMWIN;
      win = 2'd2;
      byte_sel = 3'(reg_no - IRX_MEMWIN2);
    end else if (in_win(reg_no, IRX_MEMWIN3, IRX_MEMWIN_BYTES)) begin
      region = IRX_RGN_MEMWIN;
      win = 2'd3;
      byte_sel = 3'(reg_no - IRX_MEMWIN3);
    end
  end

  // ************************************************************
  // Data byte access
  // ************************************************************
  logic data_wr;
  logic [7:0] rf_rdata;
  logic [7:0] rf_peek;

  always_comb begin
    data_wr = io_req_i.wr && hit_data;
  end

  // Read and write both index storage with the stored selector, so a data
  // access always lands on the register chosen by the last selector write.
  irx_regfile #(
    .CHIP_REV(CHIP_REV)
  ) u_regfile (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .wr_i(data_wr),
    .wr_idx_i(sel),
    .wdata_i(io_req_i.wdata),
    .rd_idx_i(sel),
    .rdata_o(rf_rdata),
    .peek_idx_i(peek_idx_i),
    .peek_o(rf_peek)
  );

  logic next_ack;
  logic [7:0] next_rdata;
  irx_wr_evt_t next_evt;

  // Reads of the data byte have no side effects here; a register whose read
  // clears status would need a read strobe, which this block does not offer.
  always_comb begin
    next_ack = (io_req_i.rd || io_req_i.wr) && (hit_sel || hit_data);
    next_rdata = io_rdata_o;
    if (io_req_i.rd && hit_sel) begin
      next_rdata = {1'b0, sel};
    end else if (io_req_i.rd && hit_data) begin
      next_rdata = rf_rdata;
    end
    next_evt.wr = data_wr;
    next_evt.idx = sel;
    next_evt.data = io_req_i.wdata;
    next_evt.region = region;
    next_evt.win = win;
    next_evt.byte_sel = byte_sel;
  end

  // The answer is registered so the host sees it exactly one cycle after the
  // request, whatever the decode depth in front of it.
  // The side read port costs a second read mux but lets a neighbour watch a
  // register without disturbing the host's selector.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_ack_o <= 1'b0;
      io_rdata_o <= 8'h00;
      wr_evt_o <= '0;
      peek_data_o <= 8'h00;
    end else begin
      io_ack_o <= next_ack;
      io_rdata_o <= next_rdata;
      wr_evt_o <= next_evt;
      peek_data_o <= rf_peek;
    end
  end

endmodule

`default_nettype wire

// File: verif/irx_top_monitor.sv
/* Port checker for irx_top.
   Assumes it is bound to irx_top and shares its clock and reset. */
`timescale 1ns/1ns
`default_nettype none
module irx_top_monitor
  import irx_pkg::*;
(
  input wire logic clk_sys_i, // Clock.
  input wire logic nrst_i, // Reset, active low.
  input wire logic [31:0] cfg_bar_rdata_o, // Base readback.
  input wire irx_pkg::irx_io_req_t io_req_i, // Host cycle.
  input wire logic io_ack_o, // Hit pulse.
  input wire logic [7:0] sel_o, // Selector.
  input wire irx_pkg::irx_wr_evt_t wr_evt_o // Write event.
);
  logic [31:0] base;
  logic any;
  logic s_hit;
  logic d_hit;
  assign base = cfg_bar_rdata_o & IRX_BAR_MASK;
  assign any = io_req_i.rd | io_req_i.wr;
  assign s_hit = any && io_req_i.addr == base;
  assign d_hit = any && io_req_i.addr == base + IRX_DATA_OFF;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_sel_wr;
    io_req_i.wr && s_hit;
  endsequence
  sequence s_dat_wr;
    io_req_i.wr && d_hit;
  endsequence
  chk_ack_hit: assert property ((s_hit || d_hit) |=> io_ack_o)
    else $error("ack missing");
  chk_ack_miss: assert property (!(s_hit || d_hit) |=> !io_ack_o)
    else $error("ack without hit");
  chk_sel_load: assert property (s_sel_wr |=> !sel_o[7]
    && sel_o[6:0] == $past(io_req_i.wdata[6:0])) else $error("sel load");
  chk_sel_hold: assert property (!(io_req_i.wr && s_hit) |=>
    $stable(sel_o)) else $error("sel moved");
  chk_evt_idx: assert property (s_dat_wr |=> wr_evt_o.wr
    && wr_evt_o.idx == $past(sel_o[6:0])
    && wr_evt_o.data == $past(io_req_i.wdata)) else $error("evt index");
  chk_evt_quiet: assert property (!(io_req_i.wr && d_hit) |=>
    !wr_evt_o.wr) else $error("stray evt");
  chk_bar_io: assert property (
    cfg_bar_rdata_o[1:0] == IRX_BAR_LOW_BITS) else $error("bar low bits");
  chk_dev_map: assert property (s_dat_wr
    ##0 sel_o[5:0] inside {[1:7]}
    |=> wr_evt_o.region == IRX_RGN_DEVCTL
    && wr_evt_o.byte_sel == $past(sel_o[2:0]) - 3'h1) else $error("devctl");
endmodule
bind irx_top irx_top_monitor i_irx_top_monitor (.clk_sys_i, .nrst_i,
  .cfg_bar_rdata_o, .io_req_i, .io_ack_o, .sel_o, .wr_evt_o);
`default_nettype wire

// File: verif/irx_host_model.sv
/* Host processor issuing byte I/O cycles.
   Assumes the one-cycle strobe port with an answer one cycle later. */
`timescale 1ns/1ns
`default_nettype none
module irx_host_model
  import irx_pkg::*;
(
  input wire logic clk_sys_i, // Clock.
  input wire logic io_ack_i, // Hit pulse.
  input wire logic [7:0] io_rdata_i, // Read data.
  output irx_pkg::irx_io_req_t io_req_o // Host cycle.
);
  initial io_req_o = '0;
  // The callers also select indices outside the register map, such as 7'h16.
  // The idle bus carries inverted values so stale data never matches.
  task automatic acc(input logic [31:0] a, input logic w,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic ok);
    @(posedge clk_sys_i);
    io_req_o <= '{addr: a, rd: !w, wr: w, wdata: d};
    @(posedge clk_sys_i);
    io_req_o <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
    @(negedge clk_sys_i);
    ok = io_ack_i === 1'b1;
    q = io_rdata_i;
  endtask
endmodule
`default_nettype wire

// File: verif/irx_top_bench.sv
/* Self-checking bench for irx_top.
   Assumes irx_host_model and the bound port checker. */
`timescale 1ns/1ns
`default_nettype none
module irx_top_bench;
  import irx_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value.
  localparam logic [31:0] BASE = 32'h0000_3C04;
  logic clk_sys_i;
  logic nrst_i;
  logic cfg_bar_wr_i;
  logic [31:0] cfg_bar_wdata_i;
  logic [31:0] cfg_bar_rdata_o;
  irx_io_req_t io_req_i;
  logic io_ack_o;
  logic [7:0] io_rdata_o;
  logic [7:0] sel_o;
  logic [7:0] peek_data_o;
  logic [7:0] q;
  logic [6:0] peek_idx_i;
  irx_wr_evt_t wr_evt_o;
  logic ok;
  int n_mismatch;
  int check_count;
  irx_top #(.CHIP_REV(REV)) i_irx_top (.clk_sys_i, .nrst_i, .cfg_bar_wr_i,
    .cfg_bar_wdata_i, .cfg_bar_rdata_o, .io_req_i, .io_ack_o, .io_rdata_o,
    .sel_o, .wr_evt_o, .peek_idx_i, .peek_data_o);
  irx_host_model i_irx_host_model (.clk_sys_i, .io_ack_i(io_ack_o),
    .io_rdata_i(io_rdata_o), .io_req_o(io_req_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    i_irx_host_model.acc(a, 1'b1, d, q, ok);
    chk(ok, 1'b1);
  endtask
  task automatic put(input logic [6:0] i, input logic [7:0] d);
    wr(BASE, {1'b0, i});
    wr(BASE + 1, d);
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    wr(BASE, {1'b0, i});
    i_irx_host_model.acc(BASE + 1, 1'b0, 8'h00, q, ok);
    chk({ok, q}, {1'b1, e});
  endtask
  task automatic t_bar;
    cfg_bar_wr_i <= 1'b1;
    cfg_bar_wdata_i <= 32'h0000_3C06;
    @(posedge clk_sys_i);
    cfg_bar_wr_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(cfg_bar_rdata_o, 32'h0000_3C05);
    $display("bar test done");
  endtask
  // Both slots are filled before any read, so aliasing shows up.
  task automatic t_map;
    logic [6:0] ix [8] = '{7'h01, 7'h07, 7'h0F, 7'h10, 7'h2D, 7'h41,
                           7'h48, 7'h6D};
    foreach (ix[k]) begin
      wr(BASE, {1'b0, ix[k]});
      chk(sel_o, {1'b0, ix[k]});
      wr(BASE + 1, {1'b1, ix[k]});
    end
    foreach (ix[k]) rd(ix[k], {1'b1, ix[k]});
    $display("map test done");
  endtask
  task automatic t_hold;
    wr(BASE, 8'hC5);
    wr(BASE + 1, 8'h11);
    wr(BASE + 1, 8'h22);
    chk(sel_o, 8'h45);
    i_irx_host_model.acc(BASE, 1'b0, 8'h00, q, ok);
    chk(q, 8'h45);
    rd(7'h45, 8'h22);
    rd(7'h46, 8'h00);
    i_irx_host_model.acc(BASE + 2, 1'b1, 8'h77, q, ok);
    chk(ok, 1'b0);
    rd(7'h45, 8'h22);
    $display("hold test done");
  endtask
  task automatic t_shared;
    put(7'h1E, 8'h5A);
    rd(7'h5E, 8'h5A);
    put(7'h5F, 8'hC3);
    rd(7'h1F, 8'hC3);
    put(7'h40, 8'hFF);
    rd(7'h00, REV);
    @(posedge clk_sys_i);
    peek_idx_i <= 7'h5E;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(peek_data_o, 8'h5A);
    $display("shared test done");
  endtask
  task automatic evt(input logic [6:0] i, input logic [7:0] e);
    put(i, {1'b0, i});
    chk({wr_evt_o.wr, wr_evt_o.idx}, {1'b1, i});
    chk({wr_evt_o.region, wr_evt_o.win, wr_evt_o.byte_sel}, e);
  endtask
  task automatic t_region;
    evt(7'h0D, {IRX_RGN_IOWIN, 2'd1, 3'd1});
    evt(7'h4A, {IRX_RGN_IOWIN, 2'd0, 3'd2});
    evt(7'h13, {IRX_RGN_MEMWIN, 2'd0, 3'd3});
    evt(7'h5A, {IRX_RGN_MEMWIN, 2'd1, 3'd2});
    evt(7'h63, {IRX_RGN_MEMWIN, 2'd2, 3'd3});
    evt(7'h2D, {IRX_RGN_MEMWIN, 2'd3, 3'd5});
    evt(7'h16, {IRX_RGN_OTHER, 2'd0, 3'd0});
    evt(7'h5F, {IRX_RGN_SHARED, 2'd0, 3'd0});
    $display("region test done");
  endtask
  // A mid-run reset must clear the selector, the storage and the base.
  task automatic t_reset;
    wr(BASE, 8'h45);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(sel_o, 8'h00);
    chk(cfg_bar_rdata_o, 32'h0000_0001);
    @(posedge clk_sys_i);
    t_bar;
    rd(7'h45, 8'h00);
    $display("reset test done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    nrst_i = 1'b0;
    cfg_bar_wr_i = 1'b0;
    cfg_bar_wdata_i = '0;
    peek_idx_i = '0;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge clk_sys_i);
    chk(cfg_bar_rdata_o, 32'h0000_0001);
    chk(sel_o, 8'h00);
    nrst_i <= 1'b1;
    t_bar;
    t_map;
    t_hold;
    t_shared;
    t_region;
    t_reset;
    end_sim;
  end
endmodule
`default_nettype wire
